/* File: csrf_map.svh */
`ifndef CSRF_MAP_SVH
`define CSRF_MAP_SVH

// reset values
`define CSRF_RSEL_RST      4'h7
`define CSRF_DIVA_RST      2'h0
// range select thresholds for the hazardous jump, and the top range for the tuning write hazard
`define CSRF_RSEL_HIGH_MIN 4'hE
`define CSRF_RSEL_LOW_MAX  4'hB
`define CSRF_RSEL_ALL_ONES 4'hF
// output dead time after a hazardous range jump
`define CSRF_DEAD_NS       20000
`define CSRF_CLK_NS        20
`define CSRF_DEAD_CYC      ((`CSRF_DEAD_NS) / (`CSRF_CLK_NS))
`define CSRF_CNT_W         10

`endif

/* File: csrf_pkg.sv */
package csrf_pkg;
  typedef logic [3:0] csrf_rsel_t;
  typedef logic [1:0] csrf_div_t;
  typedef enum logic [1:0] {
    CSRF_RUN  = 2'b00,
    CSRF_DEAD = 2'b01,
    CSRF_HUNG = 2'b11
  } csrf_osc_e;
endpackage : csrf_pkg

/* File: csrf_aux_div.sv */
`timescale 1ns/1ps
`include "csrf_map.svh"

// divides the auxiliary source by 1, 2, 4 or 8; the ratio is taken only on a source tick
module csrf_aux_div (
  input  wire logic               i_ref_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_src_tick,
  input  wire logic               i_load,
  input  wire csrf_pkg::csrf_div_t i_ratio,
  output logic                    o_tick,
  output csrf_pkg::csrf_div_t     o_ratio_in_use
);
  import csrf_pkg::*;

  csrf_div_t  ratio_q, ratio_d;
  logic [2:0] cnt_q, cnt_d;
  logic       tick_q, tick_d;

  always_comb begin
    ratio_d = ratio_q;
    cnt_d   = cnt_q;
    tick_d  = 1'b0;
    if (i_src_tick) begin
      if (i_load) begin
        ratio_d = i_ratio;
      end
      if (cnt_q >= 3'((4'h1 << ratio_q) - 4'h1)) begin
        cnt_d  = 3'h0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ratio_q <= `CSRF_DIVA_RST;
      cnt_q   <= 3'h0;
      tick_q  <= 1'b0;
    end else begin
      ratio_q <= ratio_d;
      cnt_q   <= cnt_d;
      tick_q  <= tick_d;
    end
  end

  assign o_tick         = tick_q;
  assign o_ratio_in_use = ratio_q;
endmodule : csrf_aux_div

/* File: csrf_clock_system.sv */
// How it works
// (R1) entering deep sleep mode three before an aux source tick follows a divider write drops it.
// (R2) the divider field reads back the last written value, applied or not.
// (R3) software waits one aux source period after a divider write before deep sleep.
// (R4) only the first deep sleep entry after a divider write needs that wait.
// (R5) main clock on the crystal aux clock does not fail over when a port-2 select bit clears.
// (R6) watchdog on the crystal aux clock does not fail over when a port-2 select bit clears.
// (R7) a range jump across 12..13 stops the oscillator output for about 20 us.
// (R8) such a jump may instead hang the oscillator until power is cycled.
// (R9) with range select at 15, writing step or modulation fields may cause dead time or hang.
// (R10) software goes from 14 or 15 down to 0..12 via 13.
// (R11) software goes from below 12 to above 13 via 13.
// (R12) at range 15 software returns to 7 before touching the tuning register.
// (R13) after reset the range select is seven.
// (R14) range select is a four-bit unsigned field 0..15.
`timescale 1ns/1ps
`include "csrf_map.svh"

module csrf_clock_system (
  input  wire logic                i_ref_clk,
  input  wire logic                i_arst_n,
  input  wire logic                i_aux_src_pin,
  input  wire logic                i_aux_is_crystal,
  input  wire logic                i_div_wr,
  input  wire csrf_pkg::csrf_div_t i_div_wdata,
  input  wire logic                i_deep_sleep_req,
  input  wire logic                i_rsel_wr,
  input  wire csrf_pkg::csrf_rsel_t i_rsel_wdata,
  input  wire logic                i_tune_wr,
  input  wire logic                i_hang_inject,
  input  wire logic                i_port2_sel_bit6,
  input  wire logic                i_port2_sel_bit7,
  input  wire logic                i_main_on_aux,
  input  wire logic                i_wdog_on_aux,
  output csrf_pkg::csrf_div_t      o_div_rdata,
  output csrf_pkg::csrf_div_t      o_div_in_use,
  output logic                     o_aux_tick,
  output csrf_pkg::csrf_rsel_t     o_rsel,
  output logic                     o_osc_running,
  output logic                     o_osc_hung,
  output logic                     o_main_clk_ok,
  output logic                     o_main_on_internal,
  output logic                     o_wdog_clk_ok,
  output logic                     o_wdog_on_internal
);
  import csrf_pkg::*;

  localparam int unsigned DEAD_CYC = `CSRF_DEAD_CYC;

  function automatic logic rsel_hazard(input csrf_rsel_t a, input csrf_rsel_t b);
    rsel_hazard = (a >= `CSRF_RSEL_HIGH_MIN && b <= `CSRF_RSEL_LOW_MAX) ||
                  (b >= `CSRF_RSEL_HIGH_MIN && a <= `CSRF_RSEL_LOW_MAX);
  endfunction : rsel_hazard

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic [2:0] sync_q, sync_d;
  logic       src_lvl_q, src_lvl_d;
  logic       src_tick;

  always_comb begin
    sync_d    = {sync_q[1:0], i_aux_src_pin};
    src_lvl_d = src_lvl_q;
    if (sync_q[1] == sync_q[2]) begin
      src_lvl_d = sync_q[2];
    end
  end

  assign src_tick = src_lvl_d & ~src_lvl_q;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_q    <= 3'h0;
      src_lvl_q <= 1'b0;
    end else begin
      sync_q    <= sync_d;
      src_lvl_q <= src_lvl_d;
    end
  end

  // ---------------------------------------------------------------
  // aux divider control
  // ---------------------------------------------------------------
  csrf_div_t div_shadow_q, div_shadow_d;
  logic      div_pend_q, div_pend_d;
  logic      div_load;

  always_comb begin
    div_shadow_d = div_shadow_q;
    div_pend_d   = div_pend_q;
    // (R2) readback is shadow
    if (i_div_wr) begin
      div_shadow_d = i_div_wdata;
      div_pend_d   = 1'b1;
    end else if (src_tick) begin
      div_pend_d = 1'b0;
    end else if (i_deep_sleep_req && div_pend_q) begin
      // (R1) sleep drops pending ratio
      div_pend_d = 1'b0;
    end
  end

  // (R4) only pending write at risk
  assign div_load = div_pend_q & src_tick & ~i_deep_sleep_req;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_shadow_q <= `CSRF_DIVA_RST;
      div_pend_q   <= 1'b0;
    end else begin
      div_shadow_q <= div_shadow_d;
      div_pend_q   <= div_pend_d;
    end
  end

  csrf_aux_div u_div (
    .i_ref_clk      (i_ref_clk),
    .i_arst_n       (i_arst_n),
    .i_src_tick     (src_tick),
    .i_load         (div_load),
    .i_ratio        (div_shadow_q),
    .o_tick         (o_aux_tick),
    .o_ratio_in_use (o_div_in_use)
  );

  assign o_div_rdata = div_shadow_q;

  // ---------------------------------------------------------------
  // range select and oscillator state
  // ---------------------------------------------------------------
  csrf_rsel_t        rsel_q, rsel_d;
  csrf_osc_e         osc_q, osc_d;
  logic [`CSRF_CNT_W-1:0] dead_q, dead_d;

  always_comb begin
    rsel_d = rsel_q;
    osc_d  = osc_q;
    dead_d = dead_q;
    // (R14) plain four-bit store
    if (i_rsel_wr) begin
      rsel_d = i_rsel_wdata;
    end
    case (osc_q)
      CSRF_RUN: begin
        // (R7) hazardous range jump
        if (i_rsel_wr && rsel_hazard(rsel_q, i_rsel_wdata)) begin
          // (R8) may hang instead
          osc_d  = i_hang_inject ? CSRF_HUNG : CSRF_DEAD;
          dead_d = `CSRF_CNT_W'(DEAD_CYC - 1);
        // (R9) tuning write at top range
        end else if (i_tune_wr && rsel_q == `CSRF_RSEL_ALL_ONES) begin
          osc_d  = i_hang_inject ? CSRF_HUNG : CSRF_DEAD;
          dead_d = `CSRF_CNT_W'(DEAD_CYC - 1);
        end
      end
      CSRF_DEAD: begin
        if (dead_q == '0) begin
          osc_d = CSRF_RUN;
        end else begin
          dead_d = dead_q - `CSRF_CNT_W'(1);
        end
      end
      // stays hung until reset: stands in for a power cycle
      CSRF_HUNG: osc_d = CSRF_HUNG;
      default:   osc_d = CSRF_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // (R13) default range seven
      rsel_q <= `CSRF_RSEL_RST;
      osc_q  <= CSRF_RUN;
      dead_q <= '0;
    end else begin
      rsel_q <= rsel_d;
      osc_q  <= osc_d;
      dead_q <= dead_d;
    end
  end

  assign o_rsel        = rsel_q;
  assign o_osc_running = (osc_q == CSRF_RUN);
  assign o_osc_hung    = (osc_q == CSRF_HUNG);

  // ---------------------------------------------------------------
  // failsafe
  // ---------------------------------------------------------------
  logic aux_ok, pins_ok;
  logic main_int_q, main_int_d;
  logic wdog_int_q, wdog_int_d;

  assign pins_ok = i_port2_sel_bit6 & i_port2_sel_bit7;
  // crystal aux dies with a select bit gone
  assign aux_ok  = ~i_aux_is_crystal | pins_ok;

  always_comb begin
    main_int_d = 1'b0;
    wdog_int_d = 1'b0;
    // (R5) no main failover on crystal
    if (i_main_on_aux && !pins_ok && !i_aux_is_crystal) begin
      main_int_d = 1'b1;
    end
    // (R6) no watchdog failover on crystal
    if (i_wdog_on_aux && !pins_ok && !i_aux_is_crystal) begin
      wdog_int_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      main_int_q <= 1'b0;
      wdog_int_q <= 1'b0;
    end else begin
      main_int_q <= main_int_d;
      wdog_int_q <= wdog_int_d;
    end
  end

  assign o_main_on_internal = main_int_q;
  assign o_wdog_on_internal = wdog_int_q;
  assign o_main_clk_ok      = i_main_on_aux ? aux_ok : o_osc_running;
  assign o_wdog_clk_ok      = i_wdog_on_aux ? aux_ok : o_osc_running;
endmodule : csrf_clock_system

/* File: csrf_clock_system_asserts.sv */
`timescale 1ns/1ps
`include "csrf_map.svh"
module csrf_clock_system_asserts
  import csrf_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_arst_n,
  input wire logic       i_aux_is_crystal,
  input wire logic       i_div_wr,
  input wire csrf_div_t  i_div_wdata,
  input wire logic       i_rsel_wr,
  input wire csrf_rsel_t i_rsel_wdata,
  input wire logic       i_tune_wr,
  input wire logic       i_hang_inject,
  input wire csrf_div_t  o_div_rdata,
  input wire csrf_rsel_t o_rsel,
  input wire logic       o_osc_running,
  input wire logic       o_osc_hung,
  input wire logic       o_main_on_internal,
  input wire logic       o_wdog_on_internal
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic       hz;
  logic       th;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  assign hz = i_rsel_wr && ((o_rsel >= 4'hE && i_rsel_wdata <= 4'hB) ||
                            (o_rsel <= 4'hB && i_rsel_wdata >= 4'hE));
  assign th = i_tune_wr && o_rsel == 4'hF;
  // counts dead cycles; wraps harmlessly while hung since running never rises
  always_comb cnt_d = o_osc_running ? 10'h000 : cnt_q + 10'h001;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) cnt_q <= 10'h000;
    else cnt_q <= cnt_d;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  rsel_write_a: assert property (i_rsel_wr |=> o_rsel == $past(i_rsel_wdata))
    else $error("range select not written");
  div_readback_a: assert property (i_div_wr |=> o_div_rdata == $past(i_div_wdata))
    else $error("divider readback wrong");
  jump_dead_a: assert property (hz && !i_hang_inject && o_osc_running |=>
    !o_osc_running && !o_osc_hung) else $error("range jump gave no dead time");
  dead_len_a: assert property ($rose(o_osc_running) |-> cnt_q == `CSRF_DEAD_CYC)
    else $error("dead time length wrong");
  jump_hang_a: assert property (hz && i_hang_inject && o_osc_running |=>
    o_osc_hung && !o_osc_running) else $error("range jump did not hang");
  hang_holds_a: assert property (o_osc_hung |=> o_osc_hung && !o_osc_running)
    else $error("hang released without reset");
  tune_dead_a: assert property (th && !i_hang_inject && o_osc_running |=>
    !o_osc_running) else $error("tuning write at top range kept running");
  safe_step_a: assert property (o_osc_running && !hz && !th |=> o_osc_running)
    else $error("safe step stopped oscillator");
  no_failover_a: assert property (i_aux_is_crystal && $past(i_aux_is_crystal) |->
    !o_main_on_internal && !o_wdog_on_internal) else $error("crystal failover seen");
endmodule : csrf_clock_system_asserts

bind csrf_clock_system csrf_clock_system_asserts csrf_clock_system_asserts_i (.*);

/* File: csrf_clock_system_tb.sv */
`timescale 1ns/1ps
module csrf_clock_system_tb;
  import csrf_pkg::*;
  logic i_ref_clk = 0, i_arst_n = 0, i_aux_src_pin = 0, i_aux_is_crystal = 0;
  logic i_div_wr = 0, i_deep_sleep_req = 0, i_rsel_wr = 0, i_tune_wr = 0;
  logic i_hang_inject = 0, i_port2_sel_bit6 = 1, i_port2_sel_bit7 = 1;
  logic i_main_on_aux = 1, i_wdog_on_aux = 1;
  csrf_div_t  i_div_wdata = 2'h0, o_div_rdata, o_div_in_use;
  csrf_rsel_t i_rsel_wdata = 4'h0, o_rsel;
  logic o_aux_tick, o_osc_running, o_osc_hung, o_main_clk_ok, o_main_on_internal;
  logic o_wdog_clk_ok, o_wdog_on_internal;
  int   bad_count = 0, comparisons = 0;
  int   tick_n = 0;
  csrf_clock_system csrf_clock_system_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_aux_src_pin(i_aux_src_pin), .i_aux_is_crystal(i_aux_is_crystal),
    .i_div_wr(i_div_wr), .i_div_wdata(i_div_wdata), .i_deep_sleep_req(i_deep_sleep_req),
    .i_rsel_wr(i_rsel_wr), .i_rsel_wdata(i_rsel_wdata), .i_tune_wr(i_tune_wr),
    .i_hang_inject(i_hang_inject), .i_port2_sel_bit6(i_port2_sel_bit6),
    .i_port2_sel_bit7(i_port2_sel_bit7), .i_main_on_aux(i_main_on_aux),
    .i_wdog_on_aux(i_wdog_on_aux), .o_div_rdata(o_div_rdata), .o_div_in_use(o_div_in_use),
    .o_aux_tick(o_aux_tick), .o_rsel(o_rsel), .o_osc_running(o_osc_running),
    .o_osc_hung(o_osc_hung), .o_main_clk_ok(o_main_clk_ok),
    .o_main_on_internal(o_main_on_internal), .o_wdog_clk_ok(o_wdog_clk_ok),
    .o_wdog_on_internal(o_wdog_on_internal));
  always #10 i_ref_clk = ~i_ref_clk;
  // counts divided aux pulses, sampled away from the launching edge
  always @(negedge i_ref_clk) if (o_aux_tick === 1'b1) tick_n++;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : cyc
  task do_reset;
    i_arst_n = 0;
    cyc(10);
    i_arst_n = 1;
  endtask : do_reset
  // one slow aux period; the pin is synchronised so edges land a few cycles late
  task aux_per;
    i_aux_src_pin = 1;
    cyc(10);
    i_aux_src_pin = 0;
    cyc(10);
  endtask : aux_per
  task wr_div(input csrf_div_t d, input logic s);
    i_div_wr = 1;
    i_div_wdata = d;
    cyc(1);
    i_div_wr = 0;
    // sleep entry lands on the cycle right after the write
    i_deep_sleep_req = s;
    cyc(1);
    i_deep_sleep_req = 0;
  endtask : wr_div
  task wr_rsel(input csrf_rsel_t r);
    i_rsel_wr = 1;
    i_rsel_wdata = r;
    cyc(1);
    i_rsel_wr = 0;
  endtask : wr_rsel
  task tune;
    i_tune_wr = 1;
    cyc(1);
    i_tune_wr = 0;
  endtask : tune
  task dead_wait;
    chk("running", 4'h0, o_osc_running);
    cyc(999);
    chk("running", 4'h0, o_osc_running);
    cyc(1);
    chk("running", 4'h1, o_osc_running);
  endtask : dead_wait
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_div;
    int t0;
    wr_div(2'h3, 0);
    aux_per;
    chk("in_use", 4'h3, o_div_in_use);
    wr_div(2'h1, 1);
    aux_per;
    chk("in_use", 4'h3, o_div_in_use);
    chk("rdata", 4'h1, o_div_rdata);
    wr_div(2'h2, 0);
    aux_per;
    i_deep_sleep_req = 1;
    cyc(1);
    i_deep_sleep_req = 0;
    aux_per;
    chk("in_use", 4'h2, o_div_in_use);
    t0 = tick_n;
    repeat (8) aux_per;
    chk("ticks", 4'h2, 4'(tick_n - t0));
  endtask : t_div
  task t_range;
    wr_rsel(4'hF);
    dead_wait;
    tune;
    dead_wait;
    wr_rsel(4'hD);
    chk("running", 4'h1, o_osc_running);
    wr_rsel(4'h7);
    chk("rsel", 4'h7, o_rsel);
    chk("running", 4'h1, o_osc_running);
    tune;
    chk("running", 4'h1, o_osc_running);
    wr_rsel(4'hB);
    chk("running", 4'h1, o_osc_running);
    wr_rsel(4'hE);
    dead_wait;
    wr_rsel(4'hB);
    dead_wait;
    i_hang_inject = 1;
    wr_rsel(4'hE);
    cyc(50);
    chk("hung", 4'h1, o_osc_hung);
    chk("running", 4'h0, o_osc_running);
    i_hang_inject = 0;
    do_reset;
    chk("hung", 4'h0, o_osc_hung);
    chk("rsel", 4'h7, o_rsel);
  endtask : t_range
  task t_fail;
    i_aux_is_crystal = 1;
    cyc(2);
    i_port2_sel_bit6 = 0;
    cyc(5);
    chk("main_int", 4'h0, o_main_on_internal);
    chk("main_ok", 4'h0, o_main_clk_ok);
    chk("wdog_int", 4'h0, o_wdog_on_internal);
    chk("wdog_ok", 4'h0, o_wdog_clk_ok);
    i_aux_is_crystal = 0;
    cyc(5);
    chk("main_int", 4'h1, o_main_on_internal);
    chk("wdog_int", 4'h1, o_wdog_on_internal);
  endtask : t_fail
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    cyc(1);
    do_reset;
    chk("rsel", 4'h7, o_rsel);
    chk("running", 4'h1, o_osc_running);
    t_div;
    t_range;
    t_fail;
    end_of_test;
  end
  // the run needs about 4400 cycles; five times that marks a hang
  initial begin
    #440000;
    bad_count++;
    end_of_test;
  end
endmodule : csrf_clock_system_tb
